// [logic/asp_pkg.sv]
// Purpose : Shared constants for the converter serial port block
// Assumes : 250 MHz core clock; 8-bit command byte, 24-bit register words
// Notes   : Internal conversion clock half period is a plain default

package asp_pkg;

  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  localparam int          CMD_W        = 8;
  localparam int          DATA_W       = 24;
  localparam int          ADDR_W       = 6;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  CMD_LAST     = 5'h07;  // Last bit index of command byte
  localparam logic [4:0]  DATA_LAST    = 5'h17;  // Last bit index of data word
  localparam int          CMD_WEN_BIT  = 7;      // Must be zero for a valid command
  localparam int          CMD_RD_BIT   = 6;      // One selects a read
  localparam logic [5:0]  DATA_REG_ADDR = 6'h02; // Conversion result register

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        RDY_N_RESET  = 1'h1;
  localparam logic [4:0]  CNT_RESET    = 5'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS    = 4;
  localparam int          INT_CLK_HALF_NS  = 800;
  localparam int          INT_HALF_CYC     = INT_CLK_HALF_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  INT_HALF_LAST    = 8'(INT_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // Port states
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_CMD = 3'b001,
    ST_WR  = 3'b010,
    ST_RD  = 3'b100
  } asp_state_t;

endpackage

// [logic/asp_conv_clk.sv]
// Purpose : Conversion clock source: internal divider or external pin
// Assumes : External clock is far slower than clk
// Notes   : Pin is an output only while the internal clock is selected

`timescale 1ns/1ps

module asp_conv_clk
  import asp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Mode
  input  wire logic ext_sel,
  // Clock pin
  input  wire logic clk_pin_i,
  output logic      clk_pin_o,
  output logic      clk_pin_oe,
  // Conversion tick
  output logic      conv_tick
);

  logic       pin_s1_q;
  logic       pin_s2_q;
  logic       pin_s3_q;
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic       int_q;
  logic       int_d;
  logic       oe_d;
  logic       tick_d;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // The second and third stages feed the edge detector
  always_ff @(posedge clk)
  begin
    pin_s1_q <= clk_pin_i;
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end

  // ----------------------------------------------------------------
  // Divider and source select
  // ----------------------------------------------------------------
  // Divider is cleared to zero when the pin is an input so it restarts cleanly
  always_comb
  begin
    div_d  = div_q;
    int_d  = int_q;
    oe_d   = !ext_sel;
    tick_d = 1'b0;
    if (ext_sel)
    begin
      div_d  = 8'h00;
      int_d  = 1'b0;
      tick_d = pin_s2_q && !pin_s3_q;
    end
    else if (div_q == INT_HALF_LAST)
    begin
      div_d  = 8'h00;
      int_d  = !int_q;
      tick_d = !int_q;
    end
    else
    begin
      div_d = div_q + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_q      <= 8'h00;
      int_q      <= 1'b0;
      clk_pin_oe <= 1'b0;
      conv_tick  <= 1'b0;
    end
    else
    begin
      div_q      <= div_d;
      int_q      <= int_d;
      clk_pin_oe <= oe_d;
      conv_tick  <= tick_d;
    end
  end

  assign clk_pin_o = int_q;

  a_clk_pin_drive : assert property (@(posedge clk) disable iff (rst)
    !ext_sel |=> clk_pin_oe && (ext_sel || clk_pin_o == $past(int_d)))
    else $error("Clock pin not driven by internal clock");

  a_ext_no_drive : assert property (@(posedge clk) disable iff (rst)
    ext_sel ##1 ext_sel |-> !clk_pin_oe && !clk_pin_o)
    else $error("Clock pin driven in external mode");

endmodule

// [logic/asp_serial_port.sv]
// Purpose : Serial port, ready flag and filter sync of a converter
// Assumes : Host is serial master; sclk idles high; pins are asynchronous
// Notes   : Command byte then 24-bit word; data out shared with ready
//
// Contract
// - Sync low resets filter, calibration, modulator
// - Sync leaves serial interface state untouched
// - Sync low forces a low ready high
// - Completed conversion drives ready low
// - Unread result: ready high before next update
// - Any register can be loaded for output
// - Output changes on falling serial clock edge
// - Input word goes to command-selected register
// - Continuous or burst serial clock both work
// - Chip select active low frames transfers
// - Internal clock out or external clock in

`timescale 1ns/1ps

module asp_serial_port
  import asp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Serial pins
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              din,
  output logic                   dout_rdy,
  output logic                   dout_rdy_oe,
  // Sync pin
  input  wire logic              sync_n,
  // Conversion clock pin
  input  wire logic              ext_clk_sel,
  input  wire logic              clk_pin_i,
  output logic                   clk_pin_o,
  output logic                   clk_pin_oe,
  output logic                   conv_tick,
  // Converter core
  input  wire logic              conv_done,
  input  wire logic [DATA_W-1:0] conv_data,
  input  wire logic              update_soon,
  output logic                   filt_rst,
  output logic                   cal_rst,
  output logic                   mod_rst,
  // Register file
  output logic [ADDR_W-1:0]      reg_addr,
  input  wire logic [DATA_W-1:0] reg_rd_data,
  output logic                   reg_wr_en,
  output logic [DATA_W-1:0]      reg_wr_data
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sclk_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] din_s_q;
  logic [1:0] sync_s_q;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_hi;
  logic       din_b;
  logic       sync_lo;

  // Din travels the same depth as sclk so it lines up with the edge
  always_ff @(posedge clk)
  begin
    sclk_s_q <= {sclk_s_q[1:0], sclk};
    cs_s_q   <= {cs_s_q[0], cs_n};
    din_s_q  <= {din_s_q[0], din};
    sync_s_q <= {sync_s_q[0], sync_n};
  end

  assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2];
  assign sclk_fall = !sclk_s_q[1] && sclk_s_q[2];
  assign cs_hi     = cs_s_q[1];
  assign din_b     = din_s_q[1];
  assign sync_lo   = !sync_s_q[1];

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  asp_conv_clk asp_conv_clk_inst
  (
    .clk        (clk),
    .rst        (rst),
    .ext_sel    (ext_clk_sel),
    .clk_pin_i  (clk_pin_i),
    .clk_pin_o  (clk_pin_o),
    .clk_pin_oe (clk_pin_oe),
    .conv_tick  (conv_tick)
  );

  // ----------------------------------------------------------------
  // Ready flag, result latch and core resets
  // ----------------------------------------------------------------
  logic              rdy_n_q;
  logic              rdy_n_d;
  logic              hold_q;
  logic [DATA_W-1:0] res_q;
  logic [DATA_W-1:0] res_d;
  logic              rd_done;

  // Completion wins over a read or update clear in the same cycle;
  // sync wins over all since no conversion can finish in reset
  always_comb
  begin
    rdy_n_d = rdy_n_q;
    res_d   = res_q;
    if (rd_done || (update_soon && !rdy_n_q))
    begin
      rdy_n_d = 1'b1;
    end
    if (conv_done)
    begin
      rdy_n_d = 1'b0;
      res_d   = conv_data;
    end
    if (sync_lo)
    begin
      rdy_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdy_n_q <= RDY_N_RESET;
      hold_q  <= 1'b1;
      res_q   <= '0;
    end
    else
    begin
      rdy_n_q <= rdy_n_d;
      hold_q  <= sync_lo;
      res_q   <= res_d;
    end
  end

  assign filt_rst = hold_q;
  assign cal_rst  = hold_q;
  assign mod_rst  = hold_q;

  // ----------------------------------------------------------------
  // Serial shift engine
  // ----------------------------------------------------------------
  asp_state_t        state_q;
  asp_state_t        state_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic [DATA_W-1:0] sh_q;
  logic [DATA_W-1:0] sh_d;
  logic [ADDR_W-1:0] addr_d;
  logic              load_q;
  logic              load_d;
  logic              dout_d;
  logic              oe_d;
  logic              wr_en_d;
  logic [DATA_W-1:0] wr_data_d;
  logic [DATA_W-1:0] rd_word;
  logic [CMD_W-1:0]  cmd;
  logic [DATA_W-1:0] sh_in;

  assign sh_in   = {sh_q[DATA_W-2:0], din_b};
  assign cmd     = sh_in[CMD_W-1:0];
  // Result register comes from the local latch, the rest from the register file
  assign rd_word = (reg_addr == DATA_REG_ADDR) ? res_q : reg_rd_data;

  // Every step keys on a detected edge, never on timing between
  // edges, so idle gaps in the serial clock are harmless
  always_comb
  begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    sh_d      = sh_q;
    addr_d    = reg_addr;
    load_d    = 1'b0;
    dout_d    = dout_rdy;
    oe_d      = 1'b1;
    wr_en_d   = 1'b0;
    wr_data_d = reg_wr_data;
    rd_done   = 1'b0;
    if (cs_hi)
    begin
      state_d = ST_CMD;
      cnt_d   = CNT_RESET;
      oe_d    = 1'b0;
      dout_d  = rdy_n_q;
    end
    else
    begin
      unique case (state_q)
        ST_CMD:
        begin
          dout_d = rdy_n_q;
          if (sclk_rise)
          begin
            sh_d  = sh_in;
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == CMD_LAST)
            begin
              cnt_d = CNT_RESET;
              if (!cmd[CMD_WEN_BIT])
              begin
                addr_d  = cmd[ADDR_W-1:0];
                state_d = cmd[CMD_RD_BIT] ? ST_RD : ST_WR;
                load_d  = cmd[CMD_RD_BIT];
              end
            end
          end
        end
        ST_WR:
        begin
          // Pin keeps showing ready, so a completion mid-write is seen
          dout_d = rdy_n_q;
          if (sclk_rise)
          begin
            sh_d  = sh_in;
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == DATA_LAST)
            begin
              cnt_d     = CNT_RESET;
              state_d   = ST_CMD;
              wr_en_d   = 1'b1;
              wr_data_d = sh_in;
            end
          end
        end
        ST_RD:
        begin
          if (load_q)
          begin
            sh_d = rd_word;
          end
          else if (sclk_fall)
          begin
            dout_d = sh_q[DATA_W-1];
            sh_d   = {sh_q[DATA_W-2:0], 1'b0};
          end
          else if (sclk_rise)
          begin
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == DATA_LAST)
            begin
              cnt_d   = CNT_RESET;
              state_d = ST_CMD;
              dout_d  = rdy_n_q;
              rd_done = (reg_addr == DATA_REG_ADDR);
            end
          end
        end
      endcase
    end
  end

  // Sync is deliberately absent here: the port runs on through it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q     <= ST_CMD;
      cnt_q       <= CNT_RESET;
      sh_q        <= '0;
      reg_addr    <= '0;
      load_q      <= 1'b0;
      dout_rdy    <= RDY_N_RESET;
      dout_rdy_oe <= 1'b0;
      reg_wr_en   <= 1'b0;
      reg_wr_data <= '0;
    end
    else
    begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      sh_q        <= sh_d;
      reg_addr    <= addr_d;
      load_q      <= load_d;
      dout_rdy    <= dout_d;
      dout_rdy_oe <= oe_d;
      reg_wr_en   <= wr_en_d;
      reg_wr_data <= wr_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_sync_hold_rst : assert property (@(posedge clk) disable iff (rst)
    sync_lo |=> filt_rst && mod_rst && cal_rst)
    else $error("Core not held in reset during sync");
  a_sync_keeps_port : assert property (@(posedge clk) disable iff (rst)
    (sync_lo && !cs_hi && !sclk_rise && !sclk_fall && !load_q)
      |=> state_q == $past(state_q) && cnt_q == $past(cnt_q))
    else $error("Sync disturbed the serial port");
  a_sync_rdy_high : assert property (@(posedge clk) disable iff (rst)
    sync_lo |=> rdy_n_q)
    else $error("Ready not released by sync");
  a_conv_rdy_low : assert property (@(posedge clk) disable iff (rst)
    (conv_done && !sync_lo) |=> !rdy_n_q ##1 (cs_hi || state_q != ST_CMD || !dout_rdy))
    else $error("Completion did not assert ready");
  a_update_rdy_high : assert property (@(posedge clk) disable iff (rst)
    (update_soon && !rdy_n_q && !conv_done) |=> rdy_n_q)
    else $error("Unread ready not released before update");
  a_read_load : assert property (@(posedge clk) disable iff (rst)
    (load_q && !cs_hi && state_q == ST_RD) |=> sh_q == $past(rd_word))
    else $error("Output shift register not loaded");
  a_dout_fall_only : assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_RD && !cs_hi && !sclk_fall && !sclk_rise)
      |=> dout_rdy == $past(dout_rdy))
    else $error("Output changed away from a falling edge");
  a_write_strobe : assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_WR && !cs_hi && sclk_rise && cnt_q == DATA_LAST)
      |=> reg_wr_en && reg_wr_data == $past(sh_in) ##1 !reg_wr_en)
    else $error("Write word not delivered");
  a_cs_release : assert property (@(posedge clk) disable iff (rst)
    cs_hi |=> !dout_rdy_oe && state_q == ST_CMD && cnt_q == CNT_RESET)
    else $error("Port active while deselected");

endmodule

// [bench/asp_host_model.sv]
// Purpose : Behavioural serial master standing in for the host processor
// Assumes : Serial clock idles high and stands still outside frames
// Notes   : Half period of 10 core cycles gives an 80 ns serial clock

`timescale 1ns/1ps

module asp_host_model
  import asp_pkg::*;
(
  // Timing reference
  input  wire logic clk,
  // Serial pins
  input  wire logic dout_line,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  localparam int HALF = 10;

  logic tied;                             // Chip select held low between frames

  // Idle levels at time zero
  initial
  begin
    tied = 1'b0;
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  // --------------------------------------------------------------
  // One framed transfer, MSB first; gap idles the clock per byte
  // --------------------------------------------------------------
  task automatic xfer(input logic [31:0] tx, input int nbits, input int gap,
                      output logic [31:0] rx);
    rx = '0;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge clk);
    for (int i = 31; i > 31 - nbits; i--)
    begin
      sclk = 1'b0;
      din  = tx[i];
      repeat (HALF) @(negedge clk);
      rx[i] = dout_line;                  // Sampled as the clock rises
      sclk  = 1'b1;
      repeat (HALF) @(negedge clk);
      if (gap > 0 && (i % 8) == 0)
        repeat (gap) @(negedge clk);      // Burst clocking
    end
    if (!tied)
      cs_n = 1'b1;
    din  = ~din;                          // Stale level must not look valid
    repeat (HALF) @(negedge clk);
  endtask

  // Three-wire use: chip select stays low across frames
  task automatic tie_cs(input logic on);
    tied = on;
    cs_n = !on;
  endtask
endmodule

// [bench/asp_serial_port_bench.sv]
// Purpose : Self-checking bench for the converter serial port
// Assumes : Host model frames all transfers; register file modelled here
// Notes   : Inputs change on the falling core clock edge

`timescale 1ns/1ps

module asp_serial_port_bench
  import asp_pkg::*;
  ;
  logic              clk;
  logic              rst;
  logic              sync_n;
  logic              ext_clk_sel;
  logic              ext_clk;
  logic              conv_done;
  logic              update_soon;
  logic [DATA_W-1:0] conv_data;
  logic [DATA_W-1:0] regs [0:63];
  wire logic         cs_n, sclk, din, dout_rdy, dout_rdy_oe, dout_line;
  wire logic         clk_pin_o, clk_pin_oe, clk_pin_lvl, conv_tick;
  wire logic         filt_rst, cal_rst, mod_rst, reg_wr_en;
  wire logic [ADDR_W-1:0] reg_addr;
  wire logic [DATA_W-1:0] reg_rd_data, reg_wr_data;
  int                num_errors = 0;
  int                comparisons = 0;
  int                wr_count = 0;
  int                ticks = 0;

  // --------------------------------------------------------------
  // Pins, partner and design
  // --------------------------------------------------------------
  // Released data line carries a moving value, never the last bit
  assign dout_line   = dout_rdy_oe ? dout_rdy : ~dout_rdy;
  assign clk_pin_lvl = clk_pin_oe ? clk_pin_o : ext_clk;
  assign reg_rd_data = regs[reg_addr];

  asp_host_model host_inst (.clk(clk), .dout_line(dout_line), .cs_n(cs_n),
                            .sclk(sclk), .din(din));

  asp_serial_port asp_serial_port_inst (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout_rdy(dout_rdy), .dout_rdy_oe(dout_rdy_oe), .sync_n(sync_n),
    .ext_clk_sel(ext_clk_sel), .clk_pin_i(clk_pin_lvl), .clk_pin_o(clk_pin_o),
    .clk_pin_oe(clk_pin_oe), .conv_tick(conv_tick), .conv_done(conv_done),
    .conv_data(conv_data), .update_soon(update_soon), .filt_rst(filt_rst),
    .cal_rst(cal_rst), .mod_rst(mod_rst), .reg_addr(reg_addr),
    .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data));

  // Clock and register file model
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
    for (int i = 0; i < 64; i++) regs[i] = '0;
  always @(posedge clk)
  begin
    if (reg_wr_en === 1'b1)
    begin
      regs[reg_addr] <= reg_wr_data;
      wr_count <= wr_count + 1;
    end
    if (conv_tick === 1'b1)
      ticks <= ticks + 1;
  end

  // --------------------------------------------------------------
  // Compare and helper tasks
  // --------------------------------------------------------------
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle strobe from the converter core
  task automatic pulse(input logic is_done, input logic [DATA_W-1:0] data);
    conv_data   = data;
    conv_done   = is_done;
    update_soon = ~is_done;
    @(negedge clk);
    conv_done   = 1'b0;
    update_soon = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // Writes then reads at addresses 05 and 3F, steady and burst clocking
  task automatic test_write_read();
    logic [31:0] rx;
    int          n;
    logic [5:0]  addr [2] = '{6'h05, 6'h3F};
    logic [23:0] data [2] = '{24'hA5C33C, 24'h5AF0F0};
    for (int k = 0; k < 2; k++)
    begin
      n = wr_count;
      host_inst.xfer({2'b00, addr[k], data[k]}, 32, 25 * k, rx);
      check_word(24'(wr_count - n), 24'h000001);
      check_word(regs[addr[k]], data[k]);
      host_inst.xfer({2'b01, addr[k], 24'h000000}, 32, 25 * (1 - k), rx);
      check_word(rx[23:0], data[k]);
    end
    $display("test_write_read done");
  endtask

  // Ready falls on a result and rises after the result is read
  task automatic test_ready();
    logic [31:0] rx;
    pulse(1'b1, 24'h123456);
    check_bit(dout_rdy_oe, 1'b0);
    host_inst.xfer({8'h42, 24'h000000}, 32, 0, rx);
    check_bit(rx[31], 1'b0);
    check_word(rx[23:0], 24'h123456);
    host_inst.xfer({8'h45, 24'h000000}, 32, 0, rx);
    check_bit(rx[31], 1'b1);
    $display("test_ready done");
  endtask

  // Unread result: other reads keep ready low, the update raises it
  task automatic test_update();
    logic [31:0] rx;
    pulse(1'b1, 24'h00FF00);
    host_inst.xfer({8'h45, 24'h000000}, 32, 0, rx);
    check_bit(rx[31], 1'b0);
    pulse(1'b0, 24'h00FF00);
    host_inst.xfer({8'h45, 24'h000000}, 32, 0, rx);
    check_bit(rx[31], 1'b1);
    $display("test_update done");
  endtask

  // Sync held low across a whole write
  task automatic test_sync();
    logic [31:0] rx;
    pulse(1'b1, 24'h0A0B0C);
    sync_n = 1'b0;
    repeat (5) @(negedge clk);
    check_bit(filt_rst & cal_rst & mod_rst, 1'b1);
    host_inst.xfer({8'h07, 24'h0F1E2D}, 32, 0, rx);
    check_bit(rx[31], 1'b1);
    check_word(regs[6'h07], 24'h0F1E2D);
    sync_n = 1'b1;
    repeat (5) @(negedge clk);
    check_bit(filt_rst | cal_rst | mod_rst, 1'b0);
    $display("test_sync done");
  endtask

  // Chip select raised mid-word drops it; next frame starts clean
  task automatic test_abort();
    logic [31:0] rx;
    int          n;
    n = wr_count;
    host_inst.xfer({8'h09, 24'hFFFFFF}, 16, 0, rx);
    check_word(24'(wr_count - n), 24'h000000);
    check_bit(dout_rdy_oe, 1'b0);
    host_inst.xfer({8'h09, 24'h00BEEF}, 32, 0, rx);
    check_word(regs[6'h09], 24'h00BEEF);
    // Disabled command byte is skipped; the next byte is a partial write
    n = wr_count;
    host_inst.xfer({8'h89, 24'h00ABCD}, 32, 0, rx);
    check_word(24'(wr_count - n), 24'h000000);
    check_word(regs[6'h09], 24'h00BEEF);
    $display("test_abort done");
  endtask

  // Internal divider drives the pin; external clock is counted
  task automatic test_clk_pin();
    int   t0;
    logic lvl;
    check_bit(clk_pin_oe, 1'b1);
    t0 = ticks;
    repeat (1600) @(negedge clk);
    check_word(24'(ticks - t0), 24'h000004);
    lvl = clk_pin_o;
    repeat (INT_HALF_CYC) @(negedge clk);
    check_bit(clk_pin_o, !lvl);
    ext_clk_sel = 1'b1;
    repeat (4) @(negedge clk);
    check_bit(clk_pin_oe, 1'b0);
    t0 = ticks;
    repeat (5)
    begin
      ext_clk = 1'b1;
      repeat (20) @(negedge clk);
      ext_clk = 1'b0;
      repeat (20) @(negedge clk);
    end
    check_word(24'(ticks - t0), 24'h000005);
    ext_clk_sel = 1'b0;
    $display("test_clk_pin done");
  endtask

  // Chip select tied low: a write and a read run back to back
  task automatic test_three_wire();
    logic [31:0] rx;
    host_inst.tie_cs(1'b1);
    host_inst.xfer({8'h0C, 24'h3C5A69}, 32, 0, rx);
    host_inst.xfer({8'h4C, 24'h000000}, 32, 0, rx);
    check_word(rx[23:0], 24'h3C5A69);
    check_bit(dout_rdy_oe, 1'b1);
    host_inst.tie_cs(1'b0);
    repeat (5) @(negedge clk);
    check_bit(dout_rdy_oe, 1'b0);
    $display("test_three_wire done");
  endtask

  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    sync_n = 1'b1;
    ext_clk_sel = 1'b0;
    ext_clk = 1'b0;
    conv_done = 1'b0;
    update_soon = 1'b0;
    conv_data = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    check_bit(dout_rdy_oe, 1'b0);
    test_write_read();
    test_ready();
    test_update();
    test_sync();
    test_abort();
    test_three_wire();
    test_clk_pin();
    end_of_test();
  end

  // A hang counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule
